// ==== verilog/rtc_register_bank.sv ====
/*
  Sixteen-entry byte register bank of a real-time clock: control and
  status, BCD time counters, alarm match values, square-wave and
  countdown control. Assumes the serial protocol engine, alarm matcher,
  countdown timer and divider chain live outside and talk to this bank
  through plain same-clock ports.
*/
`timescale 1ns/1ps

// Notes on behaviour
// - Writes to irrelevant bit positions have no effect.
// - Time fields hold BCD; ranges are kept by the counter logic.
// - Alarm registers hold a match value plus an enable in bit 7.
// - Bit 7 of main control selects factory test mode; resets to 0.
// - Divider halt bit clears the divider chain and stops the calendar.
// - Divider halt resets to 0; clearing it restarts from cleared divider.
// - Bit 3 of main control resets to 1, enabling reset override.
// - Pulse mode 0: interrupt follows countdown flag gated by its enable.
// - Pulse mode 1: countdown pulses; alarm flag still holds interrupt low.
// - Alarm flag bit 3: write 0 clears, write 1 keeps, resets to 0.
// - Countdown flag bit 2: write 0 clears, write 1 keeps, resets to 0.
// - Bit 1 alarm irq enable, bit 0 countdown irq enable, both reset 0.
// - Interrupt is OR of enabled alarm and enabled countdown conditions.
// - Flags set on events and hold until the host overwrites them.
// - Address pointer advances by one after each byte read or written.
// - Time counters freeze while any register is accessed, timekeeping or not.
module rtc_register_bank
  import rtc_regs_pkg::*;
(
  input  wire logic                ref_clk,
  input  wire logic                rst,
  input  wire logic                clkEn,
  // Access port from the serial engine
  input  wire logic                ptrLoad,
  input  wire logic [ADDR_W-1:0]   ptrValue,
  input  wire logic                wrStrobe,
  input  wire logic [DATA_W-1:0]   wrData,
  input  wire logic                rdStrobe,
  output logic      [DATA_W-1:0]   rdData,
  output logic      [ADDR_W-1:0]   regPointer,
  input  wire logic                accessActive,
  // Timekeeping core
  input  wire logic                tickUpdate,
  input  wire logic [DATA_W-1:0]   tickSeconds,
  input  wire logic [DATA_W-1:0]   tickMinutes,
  input  wire logic [DATA_W-1:0]   tickHours,
  input  wire logic [DATA_W-1:0]   tickDays,
  input  wire logic [DATA_W-1:0]   tickWeekday,
  input  wire logic [DATA_W-1:0]   tickMonths,
  input  wire logic [DATA_W-1:0]   tickYears,
  input  wire logic                tickCountValid,
  input  wire logic [DATA_W-1:0]   tickCountValue,
  input  wire logic                alarmEvent,
  input  wire logic                countdownEvent,
  input  wire logic                countdownPulse,
  input  wire logic                integrityLostEvent,
  // Control outputs
  output logic                     timeFreeze,
  output logic                     dividerClear,
  output logic                     factoryTestSelect,
  output logic                     resetOverrideAllow,
  output logic                     squareWaveEnable,
  output logic      [1:0]          squareWaveFreqSel,
  output logic                     countdownEnable,
  output logic      [1:0]          countdownSourceSel,
  output logic      [4*DATA_W-1:0] alarmMatch,
  output logic      [3:0]          alarmGates,
  output logic                     irqActive_n
);

  localparam int unsigned NREG = 16;

  logic [DATA_W-1:0] regs [NREG];
  logic [DATA_W-1:0] maskTable [NREG];
  logic [DATA_W-1:0] rstTable [NREG];
  logic [DATA_W-1:0] tickTable [NREG];

  // Per-register implemented bits and reset values
  assign maskTable = '{MASK_MAIN_CONTROL, MASK_IRQ_CONTROL, MASK_SECONDS, MASK_MINUTES,
                       MASK_HOURS, MASK_DAYS, MASK_WEEKDAY, MASK_MONTHS, MASK_YEARS,
                       MASK_ALARM_MINUTE, MASK_ALARM_HOUR, MASK_ALARM_DATE,
                       MASK_ALARM_DOW, MASK_SEL_CTRL, MASK_SEL_CTRL, MASK_COUNT_VALUE};
  assign rstTable  = '{RST_MAIN_CONTROL, RST_IRQ_CONTROL, RST_SECONDS, RST_ZERO, RST_ZERO,
                       RST_DAYS, RST_ZERO, RST_MONTHS, RST_ZERO, RST_ALARM, RST_ALARM,
                       RST_ALARM, RST_ALARM, RST_SQW_CTRL, RST_COUNT_CTRL, RST_ZERO};
  assign tickTable = '{RST_ZERO, RST_ZERO, tickSeconds, tickMinutes, tickHours, tickDays,
                       tickWeekday, tickMonths, tickYears, RST_ZERO, RST_ZERO, RST_ZERO,
                       RST_ZERO, RST_ZERO, RST_ZERO, tickCountValue};

  wire logic               isTimeReg;
  wire logic               byteDone;
  wire logic               calendarHalt;
  wire logic               tickAccepted;
  wire logic               writeFlags;
  wire logic [DATA_W-1:0]  flagWriteValue;
  wire logic               nextAlarmFlag;
  wire logic               nextCountFlag;
  wire logic               timerLevelIrq;
  wire logic               timerPulseIrq;
  wire logic               alarmIrq;

  assign isTimeReg    = (regPointer >= OFS_SECONDS_INTEGRITY)
                      && (regPointer <= OFS_YEAR_COUNT);
  assign byteDone     = wrStrobe | rdStrobe;
  assign calendarHalt = regs[OFS_MAIN_CONTROL][BIT_DIVIDER_HALT];
  assign timeFreeze   = accessActive | calendarHalt;
  assign tickAccepted = tickUpdate & ~timeFreeze;

  // Divider chain clear is a level; it releases when the halt bit is written 0
  assign dividerClear       = calendarHalt;
  assign factoryTestSelect  = regs[OFS_MAIN_CONTROL][BIT_FACTORY_TEST];
  assign resetOverrideAllow = regs[OFS_MAIN_CONTROL][BIT_RESET_OVR];
  assign squareWaveEnable   = regs[OFS_SQUARE_WAVE_CTRL][BIT_SQW_ENABLE];
  assign squareWaveFreqSel  = regs[OFS_SQUARE_WAVE_CTRL][1:0];
  assign countdownEnable    = regs[OFS_COUNTDOWN_CTRL][BIT_COUNT_ENABLE];
  assign countdownSourceSel = regs[OFS_COUNTDOWN_CTRL][1:0];
  assign rdData             = regs[regPointer];

  // Flags: a write ANDs in, so clearing one never clobbers the other
  assign writeFlags     = wrStrobe && (regPointer == OFS_IRQ_CONTROL_STATE);
  assign flagWriteValue = writeFlags ? wrData : 8'hff;
  assign nextAlarmFlag  = alarmEvent
                        | (regs[OFS_IRQ_CONTROL_STATE][BIT_ALARM_FLAG]
                           & flagWriteValue[BIT_ALARM_FLAG]);
  assign nextCountFlag  = countdownEvent
                        | (regs[OFS_IRQ_CONTROL_STATE][BIT_COUNT_FLAG]
                           & flagWriteValue[BIT_COUNT_FLAG]);

  // Interrupt gating
  assign alarmIrq      = regs[OFS_IRQ_CONTROL_STATE][BIT_ALARM_FLAG]
                       & regs[OFS_IRQ_CONTROL_STATE][BIT_ALARM_IRQ_EN];
  assign timerLevelIrq = regs[OFS_IRQ_CONTROL_STATE][BIT_COUNT_FLAG]
                       & regs[OFS_IRQ_CONTROL_STATE][BIT_COUNT_IRQ_EN];
  assign timerPulseIrq = countdownPulse
                       & regs[OFS_IRQ_CONTROL_STATE][BIT_COUNT_IRQ_EN];

  // Address pointer
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      regPointer <= '0;
    end else if (clkEn) begin
      if (ptrLoad) begin
        regPointer <= ptrValue;
      end else if (byteDone) begin
        regPointer <= regPointer + 4'h1;
      end
    end
  end

  // Interrupt output is registered so the open-drain pin never glitches
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irqActive_n <= 1'b1;
    end else if (clkEn) begin
      if (regs[OFS_IRQ_CONTROL_STATE][BIT_IRQ_PULSE]) begin
        irqActive_n <= ~(alarmIrq | timerPulseIrq);
      end else begin
        irqActive_n <= ~(alarmIrq | timerLevelIrq);
      end
    end
  end

  // Register storage, one slice per address
  for (genvar i = 0; i < NREG; i++) begin : g_reg
    wire logic               hostWrite;
    wire logic [DATA_W-1:0]  hostValue;
    wire logic [DATA_W-1:0]  integritySet;
    assign hostWrite = wrStrobe && (regPointer == ADDR_W'(i));
    // Loss event in the same cycle as a host write still sets the flag
    assign integritySet = (i == OFS_SECONDS_INTEGRITY && integrityLostEvent) ? 8'h80 : 8'h00;
    assign hostValue = wrData & maskTable[i];

    always_ff @(posedge ref_clk) begin
      if (rst) begin
        regs[i] <= rstTable[i];
      end else if (clkEn) begin
        if (i == OFS_IRQ_CONTROL_STATE) begin
          if (hostWrite) begin
            regs[i] <= {3'h0, hostValue[BIT_IRQ_PULSE], nextAlarmFlag,
                        nextCountFlag, hostValue[1:0]};
          end else begin
            regs[i] <= {regs[i][7:4], nextAlarmFlag, nextCountFlag, regs[i][1:0]};
          end
        end else if (hostWrite) begin
          regs[i] <= hostValue | integritySet;
        end else if (i == OFS_SECONDS_INTEGRITY && integrityLostEvent) begin
          regs[i] <= regs[i] | 8'h80;
        end else if (tickAccepted && i >= OFS_SECONDS_INTEGRITY && i <= OFS_YEAR_COUNT) begin
          // Integrity bit survives ticks; only the host clears it
          if (i == OFS_SECONDS_INTEGRITY) begin
            regs[i] <= {regs[i][BIT_INTEGRITY], tickTable[i][6:0]};
          end else begin
            regs[i] <= tickTable[i] & maskTable[i];
          end
        end else if (i == OFS_COUNTDOWN_VALUE && tickCountValid) begin
          regs[i] <= tickTable[i];
        end
      end
    end

    if (i >= OFS_ALARM_MINUTE_MATCH && i <= OFS_ALARM_DOW_MATCH) begin : g_alarm
      localparam int unsigned K = i - OFS_ALARM_MINUTE_MATCH;
      assign alarmMatch[K*DATA_W +: DATA_W] = {1'b0, regs[i][6:0]};
      assign alarmGates[K] = regs[i][BIT_ALARM_GATE];
    end
  end

endmodule // rtc_register_bank

// ==== verilog/rtc_regs_pkg.sv ====
/*
  Register map constants for the real-time clock register bank:
  offsets, bit positions and values after reset.
  Assumes a single clock domain and byte-wide registers.
*/
package rtc_regs_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;

  localparam logic [3:0] OFS_MAIN_CONTROL       = 4'h0;
  localparam logic [3:0] OFS_IRQ_CONTROL_STATE  = 4'h1;
  localparam logic [3:0] OFS_SECONDS_INTEGRITY  = 4'h2;
  localparam logic [3:0] OFS_MINUTE_COUNT       = 4'h3;
  localparam logic [3:0] OFS_HOUR_COUNT         = 4'h4;
  localparam logic [3:0] OFS_DAY_OF_MONTH       = 4'h5;
  localparam logic [3:0] OFS_DAY_OF_WEEK        = 4'h6;
  localparam logic [3:0] OFS_MONTH_AND_CENTURY  = 4'h7;
  localparam logic [3:0] OFS_YEAR_COUNT         = 4'h8;
  localparam logic [3:0] OFS_ALARM_MINUTE_MATCH = 4'h9;
  localparam logic [3:0] OFS_ALARM_HOUR_MATCH   = 4'ha;
  localparam logic [3:0] OFS_ALARM_DATE_MATCH   = 4'hb;
  localparam logic [3:0] OFS_ALARM_DOW_MATCH    = 4'hc;
  localparam logic [3:0] OFS_SQUARE_WAVE_CTRL   = 4'hd;
  localparam logic [3:0] OFS_COUNTDOWN_CTRL     = 4'he;
  localparam logic [3:0] OFS_COUNTDOWN_VALUE    = 4'hf;

  // Field positions
  localparam int unsigned BIT_FACTORY_TEST  = 7;
  localparam int unsigned BIT_DIVIDER_HALT  = 5;
  localparam int unsigned BIT_RESET_OVR     = 3;
  localparam int unsigned BIT_IRQ_PULSE     = 4;
  localparam int unsigned BIT_ALARM_FLAG    = 3;
  localparam int unsigned BIT_COUNT_FLAG    = 2;
  localparam int unsigned BIT_ALARM_IRQ_EN  = 1;
  localparam int unsigned BIT_COUNT_IRQ_EN  = 0;
  localparam int unsigned BIT_ALARM_GATE    = 7;
  localparam int unsigned BIT_SQW_ENABLE    = 7;
  localparam int unsigned BIT_COUNT_ENABLE  = 7;
  localparam int unsigned BIT_INTEGRITY     = 7;

  // Implemented-bit masks; all other bits read zero
  localparam logic [7:0] MASK_MAIN_CONTROL  = 8'ha8;
  localparam logic [7:0] MASK_IRQ_CONTROL   = 8'h1f;
  localparam logic [7:0] MASK_SECONDS       = 8'hff;
  localparam logic [7:0] MASK_MINUTES       = 8'h7f;
  localparam logic [7:0] MASK_HOURS         = 8'h3f;
  localparam logic [7:0] MASK_DAYS          = 8'h3f;
  localparam logic [7:0] MASK_WEEKDAY       = 8'h07;
  localparam logic [7:0] MASK_MONTHS        = 8'h9f;
  localparam logic [7:0] MASK_YEARS         = 8'hff;
  localparam logic [7:0] MASK_ALARM_MINUTE  = 8'hff;
  localparam logic [7:0] MASK_ALARM_HOUR    = 8'hbf;
  localparam logic [7:0] MASK_ALARM_DATE    = 8'hbf;
  localparam logic [7:0] MASK_ALARM_DOW     = 8'h87;
  localparam logic [7:0] MASK_SEL_CTRL      = 8'h83;
  localparam logic [7:0] MASK_COUNT_VALUE   = 8'hff;

  // Values after reset
  localparam logic [7:0] RST_MAIN_CONTROL   = 8'h08;
  localparam logic [7:0] RST_IRQ_CONTROL    = 8'h00;
  localparam logic [7:0] RST_SECONDS        = 8'h80;
  localparam logic [7:0] RST_DAYS           = 8'h01;
  localparam logic [7:0] RST_MONTHS         = 8'h01;
  localparam logic [7:0] RST_ALARM          = 8'h80;
  localparam logic [7:0] RST_SQW_CTRL       = 8'h80;
  localparam logic [7:0] RST_COUNT_CTRL     = 8'h03;
  localparam logic [7:0] RST_ZERO           = 8'h00;

endpackage

// ==== testbench/rtc_register_bank_props.sv ====
/*
  Port checker for the clock register bank.
  Assumes binding to rtc_register_bank and a single clock domain.
*/
`timescale 1ns/1ps
module rtc_register_bank_props
  import rtc_regs_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              rst,
  input wire logic              clkEn,
  input wire logic              ptrLoad,
  input wire logic [ADDR_W-1:0] ptrValue,
  input wire logic              wrStrobe,
  input wire logic              rdStrobe,
  input wire logic [DATA_W-1:0] rdData,
  input wire logic [ADDR_W-1:0] regPointer,
  input wire logic              accessActive,
  input wire logic              countdownPulse,
  input wire logic              timeFreeze,
  input wire logic              dividerClear,
  input wire logic              resetOverrideAllow,
  input wire logic              factoryTestSelect,
  input wire logic              irqActive_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Flag register on view: its read data is the interrupt cause
  wire logic ctlView = clkEn && regPointer == OFS_IRQ_CONTROL_STATE;

  property p_reset;
    disable iff (1'b0) rst && clkEn |=> irqActive_n && regPointer == 4'h0 && !dividerClear
      && resetOverrideAllow && !factoryTestSelect;
  endproperty
  property p_ptr_load;
    clkEn && ptrLoad |=> regPointer == $past(ptrValue);
  endproperty
  property p_ptr_step;
    clkEn && !ptrLoad && (wrStrobe || rdStrobe) |=> regPointer == $past(regPointer) + 4'h1;
  endproperty
  property p_freeze;
    timeFreeze == (accessActive || dividerClear);
  endproperty
  property p_main_view;
    regPointer == OFS_MAIN_CONTROL |-> dividerClear == rdData[5]
      && factoryTestSelect == rdData[7] && resetOverrideAllow == rdData[3];
  endproperty
  property p_unimpl;
    regPointer == OFS_MAIN_CONTROL |-> (rdData & ~MASK_MAIN_CONTROL) == 8'h00;
  endproperty
  property p_alarm_irq;
    ctlView && rdData[3] && rdData[1] |=> !irqActive_n;
  endproperty
  property p_level_irq;
    ctlView && !rdData[4] && rdData[2] && rdData[0] |=> !irqActive_n;
  endproperty
  property p_quiet;
    ctlView && !rdData[4] && !(rdData[3] && rdData[1]) && !(rdData[2] && rdData[0])
      |=> irqActive_n;
  endproperty
  property p_pulse;
    ctlView && rdData[4] && rdData[0] && !(rdData[3] && rdData[1])
      |=> irqActive_n == !$past(countdownPulse);
  endproperty

  a_reset: assert property (p_reset)
    else $error("state wrong after reset");
  a_ptr_load: assert property (p_ptr_load)
    else $error("pointer load missed");
  a_ptr_step: assert property (p_ptr_step)
    else $error("pointer did not advance by one");
  a_freeze: assert property (p_freeze)
    else $error("time freeze wrong");
  a_main_view: assert property (p_main_view)
    else $error("control outputs differ from register");
  a_unimpl: assert property (p_unimpl)
    else $error("unimplemented bit reads one");
  a_alarm_irq: assert property (p_alarm_irq)
    else $error("alarm interrupt missing");
  a_level_irq: assert property (p_level_irq)
    else $error("countdown level interrupt missing");
  a_quiet: assert property (p_quiet)
    else $error("interrupt without cause");
  a_pulse: assert property (p_pulse)
    else $error("pulse interrupt wrong");

  c_alarm: cover property (ctlView && rdData[3] && rdData[1]);
  c_pulse: cover property (ctlView && rdData[4] && countdownPulse);
  c_halt: cover property (timeFreeze && !accessActive);
endmodule // rtc_register_bank_props

// ==== testbench/rtc_host_model.sv ====
/*
  Host model standing in for the serial engine: pointer load, then one
  byte. Assumes each call starts 1 ns after a rising edge of ref_clk.
*/
`timescale 1ns/1ps
module rtc_host_model
  import rtc_regs_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic [DATA_W-1:0] rdData,
  output logic                   ptrLoad,
  output logic      [ADDR_W-1:0] ptrValue,
  output logic                   wrStrobe,
  output logic      [DATA_W-1:0] wrData,
  output logic                   rdStrobe,
  output logic                   accessActive
);
  initial begin
    {ptrLoad, wrStrobe, rdStrobe, accessActive} = 4'h0;
    ptrValue = 4'h0;
    wrData   = 8'h00;
  end
  task automatic xfer(input logic [3:0] a, input logic [7:0] d, input logic wr,
                      output logic [7:0] q);
    accessActive = 1'b1;
    ptrLoad      = 1'b1;
    ptrValue     = a;
    @(posedge ref_clk) #1;
    ptrLoad  = 1'b0;
    ptrValue = ~a;
    wrStrobe = wr;
    rdStrobe = !wr;
    wrData   = wr ? d : ~d;
    q        = rdData;
    @(posedge ref_clk) #1;
    {wrStrobe, rdStrobe, accessActive} = 3'h0;
    wrData = ~d;
  endtask
  task automatic put(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(a, d, 1'b1, q);
  endtask
  task automatic get(input logic [3:0] a, output logic [7:0] q);
    xfer(a, 8'h00, 1'b0, q);
  endtask
  // Access flag held by hand, so ticks can be offered mid access
  task automatic hold(input logic on);
    accessActive = on;
  endtask
endmodule // rtc_host_model

// ==== testbench/testbench.sv ====
/*
  Self-checking bench for the clock register bank.
  Assumes the host model and the bound port checker beside it.
*/
`timescale 1ns/1ps
module testbench;
  import rtc_regs_pkg::*;
  logic ref_clk = 1'b0, rst = 1'b1, clkEn = 1'b1, tickUpdate = 1'b0, tickCountValid = 1'b0;
  logic alarmEvent = 1'b0, countdownEvent = 1'b0, countdownPulse = 1'b0;
  logic integrityLostEvent = 1'b0;
  logic [7:0] tv = 8'h00, rd;
  wire logic ptrLoad, wrStrobe, rdStrobe, accessActive, timeFreeze, dividerClear;
  wire logic factoryTestSelect, resetOverrideAllow, squareWaveEnable, countdownEnable;
  wire logic irqActive_n;
  wire logic [3:0] ptrValue, regPointer, alarmGates;
  wire logic [7:0] wrData, rdData;
  wire logic [1:0] squareWaveFreqSel, countdownSourceSel;
  wire logic [31:0] alarmMatch;
  wire logic [13:0] ctlOuts = {factoryTestSelect, dividerClear, resetOverrideAllow, irqActive_n,
    squareWaveEnable, squareWaveFreqSel, countdownEnable, countdownSourceSel, alarmGates};
  int failCount = 0, cmpCount = 0;

  always #4 ref_clk = ~ref_clk;
  rtc_host_model host_u (.*);
  rtc_register_bank dut_u (.tickSeconds(tv), .tickMinutes(tv), .tickHours(tv), .tickDays(tv),
    .tickWeekday(tv), .tickMonths(tv), .tickYears(tv), .tickCountValue(tv), .*);

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    cmpCount++;
    if (seen !== want) begin
      failCount++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic finishTest();
    $display("comparisons %0d, mismatches %0d", cmpCount, failCount);
    if (failCount == 0 && cmpCount > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk) #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask

  task automatic tReset();
    logic [7:0] e [16] = '{8'h08, 8'h00, 8'h80, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01,
                           8'h00, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h03, 8'h00};
    chk(ctlOuts, 14'h0e3f);
    for (int i = 0; i < 16; i++) begin
      host_u.get(i[3:0], rd);
      chk(rd, e[i]);
    end
    chk(regPointer, 4'h0);
  endtask
  // All ones, except reserved-zero bits of the control pair, which the host keeps 0
  task automatic tMask();
    logic [7:0] m [16] = '{8'ha8, 8'h13, 8'hff, 8'h7f, 8'h3f, 8'h3f, 8'h07, 8'h9f,
                           8'hff, 8'hff, 8'hbf, 8'hbf, 8'h87, 8'h83, 8'h83, 8'hff};
    for (int i = 0; i < 16; i++) host_u.put(i[3:0], i == 0 ? 8'ha8 : i == 1 ? 8'h1f : 8'hff);
    chk(ctlOuts, 14'h3fff);
    chk(alarmMatch, 32'h073f3f7f);
    for (int i = 0; i < 16; i++) begin
      host_u.get(i[3:0], rd);
      chk(rd, m[i]);
    end
    for (int i = 0; i < 16; i++) host_u.put(i[3:0], 8'h00);
    chk(ctlOuts, 14'h0400);
  endtask
  task automatic tFlags();
    pulse(alarmEvent);
    pulse(countdownEvent);
    host_u.get(4'h1, rd);
    chk(rd, 8'h0c);
    host_u.put(4'h1, 8'h0a);
    host_u.get(4'h1, rd);
    chk(rd, 8'h0a);
    chk(irqActive_n, 1'b0);
    host_u.put(4'h1, 8'h01);
    cyc(1);
    chk(irqActive_n, 1'b1);
    pulse(countdownEvent);
    cyc(1);
    chk(irqActive_n, 1'b0);
    host_u.put(4'h1, 8'h11);
    pulse(countdownPulse);
    chk(irqActive_n, 1'b0);
    cyc(1);
    chk(irqActive_n, 1'b1);
    pulse(alarmEvent);
    host_u.put(4'h1, 8'h1b);
    cyc(1);
    chk(irqActive_n, 1'b0);
    clkEn = 1'b0;
    host_u.put(4'h1, 8'h00);
    clkEn = 1'b1;
    host_u.get(4'h1, rd);
    chk(rd, 8'h1b);
    host_u.put(4'h1, 8'h00);
  endtask
  task automatic tTime();
    tv = 8'h45;
    host_u.hold(1'b1);
    pulse(tickUpdate);
    host_u.hold(1'b0);
    host_u.get(4'h2, rd);
    chk(rd, 8'h00);
    pulse(tickUpdate);
    host_u.get(4'h4, rd);
    chk(rd, 8'h05);
    host_u.put(4'h0, 8'h20);
    chk({dividerClear, timeFreeze}, 2'b11);
    tv = 8'h12;
    pulse(tickUpdate);
    pulse(integrityLostEvent);
    host_u.put(4'h0, 8'h00);
    chk(dividerClear, 1'b0);
    host_u.get(4'h2, rd);
    chk(rd, 8'hc5);
    pulse(tickCountValid);
    host_u.get(4'hf, rd);
    chk(rd, 8'h12);
    chk(regPointer, 4'h0);
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    failCount++;
    finishTest();
  end
  initial begin
    repeat (6) @(posedge ref_clk) #1;
    rst = 1'b0;
    tReset();
    tMask();
    tFlags();
    tTime();
    finishTest();
  end
endmodule // testbench

bind rtc_register_bank rtc_register_bank_props chk_u (.*);
